// *** rtl/ifs_pkg.sv ***
// Constants for the interrupt flag, FIFO status and collision display register block
package ifs_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [5:0] IFS_ADDR_MASK_TF = 6'h15;
    localparam logic [5:0] IFS_ADDR_MASK_EW = 6'h16;
    localparam logic [5:0] IFS_ADDR_TF = 6'h18;
    localparam logic [5:0] IFS_ADDR_EW = 6'h19;
    localparam logic [5:0] IFS_ADDR_FIFO1 = 6'h1A;
    localparam logic [5:0] IFS_ADDR_FIFO2 = 6'h1B;
    localparam logic [5:0] IFS_ADDR_COL = 6'h1C;

    localparam logic [7:0] IFS_REG_RESET = 8'h00;

    // ****************************************
    // Timer and field event flag bits
    // ****************************************
    localparam int IFS_TF_DCT = 7;
    localparam int IFS_TF_NRE = 6;
    localparam int IFS_TF_GPE = 5;
    localparam int IFS_TF_EON = 4;
    localparam int IFS_TF_EOF = 3;
    localparam int IFS_TF_CAC = 2;
    localparam int IFS_TF_CAT = 1;
    localparam int IFS_TF_NFCT = 0;

    // ****************************************
    // Error and wake-up flag bits
    // ****************************************
    localparam int IFS_EW_CRC = 7;
    localparam int IFS_EW_PAR = 6;
    localparam int IFS_EW_SOFT = 5;
    localparam int IFS_EW_HARD = 4;
    localparam int IFS_EW_WT = 3;
    localparam int IFS_EW_WAM = 2;
    localparam int IFS_EW_WPH = 1;
    localparam int IFS_EW_WCAP = 0;

    // ****************************************
    // FIFO status fields
    // ****************************************
    localparam int IFS_FILL_W = 7;
    localparam logic [6:0] IFS_FILL_EMPTY = 7'h00;
    localparam logic [6:0] IFS_FILL_MAX = 7'h60;
    localparam int IFS_F2_UNF = 6;
    localparam int IFS_F2_OVR = 5;
    localparam int IFS_F2_NCP = 4;
    localparam int IFS_F2_LB_HI = 3;
    localparam int IFS_F2_LB_LO = 1;
    localparam int IFS_F2_NP = 0;

    // ****************************************
    // Collision display fields
    // ****************************************
    localparam int IFS_COL_BYTES_W = 13;
    localparam int IFS_COL_BYTE_HI = 7;
    localparam int IFS_COL_BYTE_LO = 4;
    localparam int IFS_COL_BIT_HI = 3;
    localparam int IFS_COL_BIT_LO = 1;
    localparam int IFS_COL_PB = 0;

    // ****************************************
    // Wake-up measurements
    // ****************************************
    localparam int IFS_MEAS_W = 8;
    localparam int IFS_MEAS_N = 3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int IFS_CLK_MHZ = 125;
    localparam int IFS_SENSE_TIME_NS = 1000;
    localparam int IFS_GUARD_TIME_NS = 5000;
    localparam int IFS_SENSE_CYCLES = (IFS_SENSE_TIME_NS * IFS_CLK_MHZ + 999) / 1000;
    localparam int IFS_GUARD_CYCLES = (IFS_GUARD_TIME_NS * IFS_CLK_MHZ + 999) / 1000;
    localparam int IFS_CNT_W = 12;

    typedef enum logic [1:0] {
        IFS_CA_IDLE,
        IFS_CA_SENSE,
        IFS_CA_GUARD
    } ifs_ca_state_type;

endpackage

// *** rtl/ifs_coll_avoid.sv ***
// RF collision avoidance sequencer with external field sensing
`timescale 1ns/1ps
module ifs_coll_avoid import ifs_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic set_default,
    input wire logic ca_start,
    input wire logic rf_off,
    input wire logic ext_field_pin,
    // Results
    output logic field_on,
    output logic ev_eon,
    output logic ev_eof,
    output logic ev_cac,
    output logic ev_cat
);

    ifs_ca_state_type state_r, state_nxt;
    logic [IFS_CNT_W-1:0] cnt_r, cnt_nxt;
    logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
    logic field_on_r, field_on_nxt;
    logic eon_r, eon_nxt, eof_r, eof_nxt, cac_r, cac_nxt, cat_r, cat_nxt;

    // ****************************************
    // Field level filter and sequence
    // ****************************************
    always_comb begin
        // A change counts only once the last two stages agree
        lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
        eon_nxt = lvl_nxt && !lvl_r;
        eof_nxt = !lvl_nxt && lvl_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        field_on_nxt = field_on_r;
        cac_nxt = 1'b0;
        cat_nxt = 1'b0;
        if (rf_off) begin
            field_on_nxt = 1'b0;
        end
        case (state_r)
            IFS_CA_IDLE: begin
                if (ca_start) begin
                    state_nxt = IFS_CA_SENSE;
                    cnt_nxt = IFS_CNT_W'(IFS_SENSE_CYCLES - 1);
                end
            end
            IFS_CA_SENSE: begin
                if (lvl_r) begin
                    cac_nxt = 1'b1;
                    state_nxt = IFS_CA_IDLE;
                end else if (cnt_r == '0) begin
                    field_on_nxt = 1'b1;
                    state_nxt = IFS_CA_GUARD;
                    cnt_nxt = IFS_CNT_W'(IFS_GUARD_CYCLES - 1);
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            IFS_CA_GUARD: begin
                if (cnt_r == '0) begin
                    cat_nxt = 1'b1;
                    state_nxt = IFS_CA_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = IFS_CA_IDLE;
            end
        endcase
        if (set_default) begin
            state_nxt = IFS_CA_IDLE;
            cnt_nxt = '0;
            field_on_nxt = 1'b0;
            cac_nxt = 1'b0;
            cat_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
            state_r <= IFS_CA_IDLE;
            cnt_r <= '0;
            field_on_r <= 1'b0;
            eon_r <= 1'b0;
            eof_r <= 1'b0;
            cac_r <= 1'b0;
            cat_r <= 1'b0;
        end else begin
            s1_r <= ext_field_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            field_on_r <= field_on_nxt;
            eon_r <= eon_nxt;
            eof_r <= eof_nxt;
            cac_r <= cac_nxt;
            cat_r <= cat_nxt;
        end
    end

    assign field_on = field_on_r;
    assign ev_eon = eon_r;
    assign ev_eof = eof_r;
    assign ev_cac = cac_r;
    assign ev_cat = cat_r;

endmodule

// *** rtl/ifs_status_regs.sv ***
// Interrupt flag, FIFO status and collision display registers with masks and request
`timescale 1ns/1ps
module ifs_status_regs import ifs_pkg::*; (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Register port
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Commands
    input wire logic SET_DEFAULT,
    input wire logic CA_START,
    input wire logic RF_OFF,
    // Timer and field events
    input wire logic EV_CMD_DONE,
    input wire logic EV_NORESP_TIMEOUT,
    input wire logic EV_GPT_TIMEOUT,
    input wire logic EV_INIT_RATE_FOUND,
    input wire logic EXT_FIELD_PIN,
    output logic FIELD_ON,
    // Receive errors
    input wire logic EV_CRC_ERR,
    input wire logic EV_PARITY_ERR,
    input wire logic EV_SOFT_FRAMING,
    input wire logic EV_HARD_FRAMING,
    // Wake-up
    input wire logic WT_TIMEOUT,
    input wire logic WT_IRQ_EVERY,
    input wire logic [IFS_MEAS_N-1:0] MEAS_DONE,
    input wire logic [IFS_MEAS_W-1:0] AM_VALUE,
    input wire logic [IFS_MEAS_W-1:0] AM_REF,
    input wire logic [IFS_MEAS_W-1:0] AM_DELTA,
    input wire logic [IFS_MEAS_W-1:0] PM_VALUE,
    input wire logic [IFS_MEAS_W-1:0] PM_REF,
    input wire logic [IFS_MEAS_W-1:0] PM_DELTA,
    input wire logic [IFS_MEAS_W-1:0] CM_VALUE,
    input wire logic [IFS_MEAS_W-1:0] CM_REF,
    input wire logic [IFS_MEAS_W-1:0] CM_DELTA,
    // FIFO
    input wire logic [IFS_FILL_W-1:0] FIFO_COUNT,
    input wire logic FIFO_UNDERFLOW,
    input wire logic FIFO_OVERFLOW,
    input wire logic RX_LAST_PARTIAL,
    input wire logic [2:0] RX_LAST_BITS,
    input wire logic RX_PARITY_MISSING,
    // Bit collision
    input wire logic RX_FRAME_START,
    input wire logic COL_EVENT,
    input wire logic [IFS_COL_BYTES_W-1:0] COL_BYTES,
    input wire logic [2:0] COL_BIT,
    input wire logic COL_IN_PARITY,
    // Interrupt
    output logic IRQ,
    output logic SUM_TIM,
    output logic SUM_ERR
);

    logic [7:0] tf_r, tf_nxt, ew_r, ew_nxt;
    logic [7:0] mask_tf_r, mask_tf_nxt, mask_ew_r, mask_ew_nxt;
    logic [7:0] fill_r, fill_nxt, f2_r, f2_nxt, col_r, col_nxt;
    logic col_seen_r, col_seen_nxt;
    logic sum_tim_r, sum_tim_nxt, sum_err_r, sum_err_nxt, irq_r, irq_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [7:0] tf_set, ew_set;
    logic rd_tf, rd_ew, rd_f2;
    logic ca_field_on, ca_eon, ca_eof, ca_cac, ca_cat;
    logic [IFS_MEAS_W-1:0] meas_val [IFS_MEAS_N];
    logic [IFS_MEAS_W-1:0] meas_ref [IFS_MEAS_N];
    logic [IFS_MEAS_W-1:0] meas_dlt [IFS_MEAS_N];
    logic [IFS_MEAS_N-1:0] meas_hit;

    // ****************************************
    // Collision avoidance and field sensing
    // ****************************************
    ifs_coll_avoid u_ca (
        .clk(CLOCK),
        .nrst(NRST),
        .set_default(SET_DEFAULT),
        .ca_start(CA_START),
        .rf_off(RF_OFF),
        .ext_field_pin(EXT_FIELD_PIN),
        .field_on(ca_field_on),
        .ev_eon(ca_eon),
        .ev_eof(ca_eof),
        .ev_cac(ca_cac),
        .ev_cat(ca_cat)
    );

    // ****************************************
    // Wake-up measurement comparison
    // ****************************************
    // Index 2 amplitude, 1 phase, 0 capacitance, matching the flag bits
    assign meas_val[2] = AM_VALUE;
    assign meas_ref[2] = AM_REF;
    assign meas_dlt[2] = AM_DELTA;
    assign meas_val[1] = PM_VALUE;
    assign meas_ref[1] = PM_REF;
    assign meas_dlt[1] = PM_DELTA;
    assign meas_val[0] = CM_VALUE;
    assign meas_ref[0] = CM_REF;
    assign meas_dlt[0] = CM_DELTA;

    genvar gi;
    generate
        for (gi = 0; gi < IFS_MEAS_N; gi++) begin : g_meas
            logic [IFS_MEAS_W-1:0] diff;
            // Absolute difference, so drift in either direction wakes
            assign diff = (meas_val[gi] > meas_ref[gi]) ? (meas_val[gi] - meas_ref[gi])
                                                        : (meas_ref[gi] - meas_val[gi]);
            assign meas_hit[gi] = MEAS_DONE[gi] && (diff > meas_dlt[gi]);
        end
    endgenerate

    // ****************************************
    // Event sources per flag bit
    // ****************************************
    always_comb begin
        tf_set = 8'h00;
        tf_set[IFS_TF_DCT] = EV_CMD_DONE;
        tf_set[IFS_TF_NRE] = EV_NORESP_TIMEOUT;
        tf_set[IFS_TF_GPE] = EV_GPT_TIMEOUT;
        tf_set[IFS_TF_EON] = ca_eon;
        tf_set[IFS_TF_EOF] = ca_eof;
        tf_set[IFS_TF_CAC] = ca_cac;
        tf_set[IFS_TF_CAT] = ca_cat;
        tf_set[IFS_TF_NFCT] = EV_INIT_RATE_FOUND;
        ew_set = 8'h00;
        ew_set[IFS_EW_CRC] = EV_CRC_ERR;
        ew_set[IFS_EW_PAR] = EV_PARITY_ERR;
        ew_set[IFS_EW_SOFT] = EV_SOFT_FRAMING;
        ew_set[IFS_EW_HARD] = EV_HARD_FRAMING;
        ew_set[IFS_EW_WT] = WT_TIMEOUT && WT_IRQ_EVERY;
        ew_set[IFS_EW_WAM] = meas_hit[2];
        ew_set[IFS_EW_WPH] = meas_hit[1];
        ew_set[IFS_EW_WCAP] = meas_hit[0];
    end

    // ****************************************
    // Register next state
    // ****************************************
    always_comb begin
        rd_tf = REG_RD && (REG_ADDR == IFS_ADDR_TF);
        rd_ew = REG_RD && (REG_ADDR == IFS_ADDR_EW);
        rd_f2 = REG_RD && (REG_ADDR == IFS_ADDR_FIFO2);

        // Masks
        mask_tf_nxt = mask_tf_r;
        mask_ew_nxt = mask_ew_r;
        if (REG_WR && (REG_ADDR == IFS_ADDR_MASK_TF)) begin
            mask_tf_nxt = REG_WDATA;
        end
        if (REG_WR && (REG_ADDR == IFS_ADDR_MASK_EW)) begin
            mask_ew_nxt = REG_WDATA;
        end

        // Flags: a read clears, an event in the same cycle still lands
        tf_nxt = (rd_tf ? IFS_REG_RESET : tf_r) | tf_set;
        ew_nxt = (rd_ew ? IFS_REG_RESET : ew_r) | ew_set;
        sum_tim_nxt = (rd_tf ? 1'b0 : sum_tim_r) | (|(tf_set & ~mask_tf_r));
        sum_err_nxt = (rd_ew ? 1'b0 : sum_err_r) | (|(ew_set & ~mask_ew_r));

        // Fill level, bit 7 always zero; empty FIFO gives 00h directly
        fill_nxt = {1'b0, FIFO_COUNT};

        // Second FIFO status
        f2_nxt = f2_r;
        if (rd_f2) begin
            f2_nxt[IFS_F2_NCP] = 1'b0;
            f2_nxt[IFS_F2_LB_HI:IFS_F2_LB_LO] = 3'h0;
            f2_nxt[IFS_F2_NP] = 1'b0;
        end
        if (FIFO_COUNT == IFS_FILL_EMPTY) begin
            f2_nxt[IFS_F2_NCP] = 1'b0;
            f2_nxt[IFS_F2_LB_HI:IFS_F2_LB_LO] = 3'h0;
        end
        if (FIFO_UNDERFLOW) begin
            f2_nxt[IFS_F2_UNF] = 1'b1;
        end
        if (FIFO_OVERFLOW) begin
            f2_nxt[IFS_F2_OVR] = 1'b1;
        end
        if (RX_LAST_PARTIAL) begin
            f2_nxt[IFS_F2_NCP] = 1'b1;
            f2_nxt[IFS_F2_LB_HI:IFS_F2_LB_LO] = RX_LAST_BITS;
        end
        if (RX_PARITY_MISSING) begin
            f2_nxt[IFS_F2_NP] = 1'b1;
        end

        // Collision display keeps only the first collision of a frame
        col_nxt = col_r;
        col_seen_nxt = col_seen_r;
        if (RX_FRAME_START) begin
            col_seen_nxt = 1'b0;
        end
        if (COL_EVENT && !col_seen_r) begin
            col_seen_nxt = 1'b1;
            // Byte count beyond four bits means a long message: leave display alone
            if (COL_BYTES[IFS_COL_BYTES_W-1:IFS_COL_BYTE_HI-IFS_COL_BYTE_LO+1] == '0) begin
                col_nxt[IFS_COL_BYTE_HI:IFS_COL_BYTE_LO] = COL_BYTES[IFS_COL_BYTE_HI-IFS_COL_BYTE_LO:0];
                col_nxt[IFS_COL_BIT_HI:IFS_COL_BIT_LO] = COL_BIT;
                col_nxt[IFS_COL_PB] = COL_IN_PARITY;
            end
        end

        // Read data from current contents, before any clear-on-read
        rvalid_nxt = REG_RD;
        rdata_nxt = IFS_REG_RESET;
        if (REG_RD) begin
            case (REG_ADDR)
                IFS_ADDR_MASK_TF: rdata_nxt = mask_tf_r;
                IFS_ADDR_MASK_EW: rdata_nxt = mask_ew_r;
                IFS_ADDR_TF: rdata_nxt = tf_r;
                IFS_ADDR_EW: rdata_nxt = ew_r;
                IFS_ADDR_FIFO1: rdata_nxt = fill_r;
                IFS_ADDR_FIFO2: rdata_nxt = f2_r;
                IFS_ADDR_COL: rdata_nxt = col_r;
                default: rdata_nxt = IFS_REG_RESET;
            endcase
        end

        if (SET_DEFAULT) begin
            tf_nxt = IFS_REG_RESET;
            ew_nxt = IFS_REG_RESET;
            mask_tf_nxt = IFS_REG_RESET;
            mask_ew_nxt = IFS_REG_RESET;
            fill_nxt = IFS_REG_RESET;
            f2_nxt = IFS_REG_RESET;
            col_nxt = IFS_REG_RESET;
            col_seen_nxt = 1'b0;
            sum_tim_nxt = 1'b0;
            sum_err_nxt = 1'b0;
        end

        // Request follows the flag contents on the same edge that they change
        irq_nxt = (|(tf_nxt & ~mask_tf_nxt)) || (|(ew_nxt & ~mask_ew_nxt));
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            tf_r <= IFS_REG_RESET;
            ew_r <= IFS_REG_RESET;
            mask_tf_r <= IFS_REG_RESET;
            mask_ew_r <= IFS_REG_RESET;
            fill_r <= IFS_REG_RESET;
            f2_r <= IFS_REG_RESET;
            col_r <= IFS_REG_RESET;
            col_seen_r <= 1'b0;
            sum_tim_r <= 1'b0;
            sum_err_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= IFS_REG_RESET;
            rvalid_r <= 1'b0;
        end else begin
            tf_r <= tf_nxt;
            ew_r <= ew_nxt;
            mask_tf_r <= mask_tf_nxt;
            mask_ew_r <= mask_ew_nxt;
            fill_r <= fill_nxt;
            f2_r <= f2_nxt;
            col_r <= col_nxt;
            col_seen_r <= col_seen_nxt;
            sum_tim_r <= sum_tim_nxt;
            sum_err_r <= sum_err_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign REG_RVALID = rvalid_r;
    assign IRQ = irq_r;
    assign SUM_TIM = sum_tim_r;
    assign SUM_ERR = sum_err_r;
    assign FIELD_ON = ca_field_on;

endmodule

// *** verification/ifs_status_regs_sva.sv ***
// Checker on the status register block ports
`timescale 1ns/1ps
module ifs_status_regs_sva import ifs_pkg::*; (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Register port
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    // Inputs watched
    input wire logic SET_DEFAULT,
    input wire logic RF_OFF,
    input wire logic EV_CMD_DONE,
    input wire logic EV_CRC_ERR,
    input wire logic [IFS_FILL_W-1:0] FIFO_COUNT,
    input wire logic FIFO_UNDERFLOW,
    input wire logic RX_LAST_PARTIAL,
    // Outputs watched
    input wire logic FIELD_ON,
    input wire logic IRQ,
    input wire logic SUM_TIM,
    input wire logic SUM_ERR
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // ****************************************
    // Mask shadow for the two watched events
    // ****************************************
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    always_comb begin
        mask_nxt = mask_r;
        if (REG_WR && REG_ADDR == IFS_ADDR_MASK_TF) mask_nxt[1] = REG_WDATA[IFS_TF_DCT];
        if (REG_WR && REG_ADDR == IFS_ADDR_MASK_EW) mask_nxt[0] = REG_WDATA[IFS_EW_CRC];
        if (SET_DEFAULT) mask_nxt = 2'h0;
    end
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) mask_r <= 2'h0;
        else mask_r <= mask_nxt;
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_rd_ans; REG_RD |=> REG_RVALID; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_idle; !REG_RD |=> !REG_RVALID && REG_RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_crc_irq; EV_CRC_ERR && !mask_r[0] && !SET_DEFAULT |=> IRQ && SUM_ERR; endproperty
    a_crc_irq: assert property (p_crc_irq) else $error("unmasked error gave no request");
    property p_dct_sum; EV_CMD_DONE && !mask_r[1] && !SET_DEFAULT |=> SUM_TIM; endproperty
    a_dct_sum: assert property (p_dct_sum) else $error("timer summary not set");
    property p_sd; SET_DEFAULT |=> !IRQ && !SUM_TIM && !SUM_ERR; endproperty
    a_sd: assert property (p_sd) else $error("set default left request");
    property p_fill;
        REG_RD && REG_ADDR == IFS_ADDR_FIFO1 && $stable(FIFO_COUNT) && $past(NRST) && !$past(SET_DEFAULT)
        |=> REG_RDATA == {1'b0, $past(FIFO_COUNT)};
    endproperty
    a_fill: assert property (p_fill) else $error("fill count wrong");
    property p_unf;
        FIFO_UNDERFLOW && !SET_DEFAULT ##1 REG_RD && REG_ADDR == IFS_ADDR_FIFO2 && !SET_DEFAULT |=> REG_RDATA[6];
    endproperty
    a_unf: assert property (p_unf) else $error("underflow not shown");
    property p_empty;
        FIFO_COUNT == 7'h00 && !RX_LAST_PARTIAL ##1 REG_RD && REG_ADDR == IFS_ADDR_FIFO2 |=> REG_RDATA[4:1] == 4'h0;
    endproperty
    a_empty: assert property (p_empty) else $error("empty fifo kept last byte info");
    property p_rf_off; RF_OFF && FIELD_ON |=> !FIELD_ON; endproperty
    a_rf_off: assert property (p_rf_off) else $error("field stayed on");
endmodule
bind ifs_status_regs ifs_status_regs_sva ifs_status_regs_sva_inst (.*);

// *** verification/ifs_host_model.sv ***
// Host model driving the register port
`timescale 1ns/1ps
module ifs_host_model import ifs_pkg::*; (
    // Clock
    input wire logic clk,
    // Register port
    output logic rd,
    output logic wr,
    output logic [5:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial begin
        rd = 1'b0;
        wr = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
    end
    // Address inverted after use so stale values never look valid
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rvalid ? rdata : 8'hXX;
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    // Second status kept because reading it clears last byte info
    task automatic fifo_status(output logic [7:0] f1, output logic [7:0] f2);
        rd_reg(IFS_ADDR_FIFO1, f1);
        rd_reg(IFS_ADDR_FIFO2, f2);
    endtask
endmodule

// *** verification/ifs_status_regs_bench.sv ***
// Self-checking bench for the status register block
`timescale 1ns/1ps
module ifs_status_regs_bench import ifs_pkg::*; ;
    logic CLOCK = 1'b0, NRST = 1'b0, REG_RD, REG_WR, REG_RVALID, FIELD_ON, IRQ, SUM_TIM, SUM_ERR;
    logic [5:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA, rv, f1, f2;
    logic SET_DEFAULT = 1'b0, CA_START = 1'b0, RF_OFF = 1'b0, EXT_FIELD_PIN = 1'b0;
    logic EV_CMD_DONE = 1'b0, EV_NORESP_TIMEOUT = 1'b0, EV_GPT_TIMEOUT = 1'b0, EV_INIT_RATE_FOUND = 1'b0;
    logic EV_CRC_ERR = 1'b0, EV_PARITY_ERR = 1'b0, EV_SOFT_FRAMING = 1'b0, EV_HARD_FRAMING = 1'b0;
    logic WT_TIMEOUT = 1'b0, WT_IRQ_EVERY = 1'b0, FIFO_UNDERFLOW = 1'b0, FIFO_OVERFLOW = 1'b0;
    logic [IFS_MEAS_N-1:0] MEAS_DONE = '0;
    logic [IFS_MEAS_W-1:0] AM_VALUE = '0, AM_REF = '0, AM_DELTA = '0, PM_VALUE = '0, PM_REF = '0, PM_DELTA = '0;
    logic [IFS_MEAS_W-1:0] CM_VALUE = '0, CM_REF = '0, CM_DELTA = '0;
    logic [IFS_FILL_W-1:0] FIFO_COUNT = '0;
    logic RX_LAST_PARTIAL = 1'b0, RX_PARITY_MISSING = 1'b0, RX_FRAME_START = 1'b0, COL_EVENT = 1'b0;
    logic COL_IN_PARITY = 1'b0;
    logic [2:0] RX_LAST_BITS = '0, COL_BIT = '0;
    logic [IFS_COL_BYTES_W-1:0] COL_BYTES = '0;
    int errors = 0, checked = 0, cycles = 0, n;
    ifs_status_regs ifs_status_regs_inst (.*);
    ifs_host_model ifs_host_model_inst (.clk(CLOCK), .rd(REG_RD), .wr(REG_WR), .addr(REG_ADDR),
        .wdata(REG_WDATA), .rdata(REG_RDATA), .rvalid(REG_RVALID));
    always #4 CLOCK = ~CLOCK;
    // Whole run needs about 1100 cycles
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        ifs_host_model_inst.rd_reg(a, rv);
        chk(rv, exp);
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge CLOCK);
    endtask
    task automatic col(input logic start, input logic [12:0] b, input logic [2:0] k, input logic p);
        @(negedge CLOCK);
        {RX_FRAME_START, COL_EVENT, COL_BYTES, COL_BIT, COL_IN_PARITY} = {start, !start, b, k, p};
        @(negedge CLOCK);
        {RX_FRAME_START, COL_EVENT} = 2'h0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        for (int a = 24; a <= 28; a++) rchk(6'(a), 8'h00);
        rchk(6'h3F, 8'h00);
    endtask
    task automatic t_tf();
        {EV_CMD_DONE, EV_NORESP_TIMEOUT, EV_GPT_TIMEOUT, EV_INIT_RATE_FOUND} = 4'hF;
        tick(1);
        {EV_CMD_DONE, EV_NORESP_TIMEOUT, EV_GPT_TIMEOUT, EV_INIT_RATE_FOUND} = 4'h0;
        chk({6'h00, SUM_TIM, IRQ}, 8'h03);
        rchk(IFS_ADDR_TF, 8'hE1);
        rchk(IFS_ADDR_TF, 8'h00);
        chk({7'h00, SUM_TIM}, 8'h00);
    endtask
    task automatic t_ew();
        {EV_CRC_ERR, EV_PARITY_ERR, EV_SOFT_FRAMING, EV_HARD_FRAMING, WT_TIMEOUT} = 5'h1F;
        tick(1);
        {EV_CRC_ERR, EV_PARITY_ERR, EV_SOFT_FRAMING, EV_HARD_FRAMING, WT_TIMEOUT} = 5'h00;
        rchk(IFS_ADDR_EW, 8'hF0);
        {AM_VALUE, AM_REF, AM_DELTA, PM_VALUE, PM_REF, PM_DELTA} = {8'h32, 8'h28, 8'h0A, 8'h1E, 8'h28, 8'h09};
        {CM_VALUE, CM_REF, CM_DELTA, WT_IRQ_EVERY} = {8'h65, 8'h64, 8'h00, 1'b1};
        tick(1);
        {MEAS_DONE, WT_TIMEOUT} = 4'hF;
        tick(1);
        {MEAS_DONE, WT_TIMEOUT} = 4'h0;
        rchk(IFS_ADDR_EW, 8'h0B);
        rchk(IFS_ADDR_EW, 8'h00);
    endtask
    task automatic t_mask();
        ifs_host_model_inst.wr_reg(IFS_ADDR_MASK_EW, 8'h80);
        rchk(IFS_ADDR_MASK_EW, 8'h80);
        ifs_host_model_inst.wr_reg(IFS_ADDR_MASK_TF, 8'h02);
        rchk(IFS_ADDR_MASK_TF, 8'h02);
        EV_CRC_ERR = 1'b1;
        tick(1);
        EV_CRC_ERR = 1'b0;
        tick(1);
        chk({6'h00, SUM_ERR, IRQ}, 8'h00);
        rchk(IFS_ADDR_EW, 8'h80);
        ifs_host_model_inst.wr_reg(IFS_ADDR_MASK_EW, 8'h00);
        EV_PARITY_ERR = 1'b1;
        tick(1);
        EV_PARITY_ERR = 1'b0;
        chk({7'h00, IRQ}, 8'h01);
        rchk(IFS_ADDR_EW, 8'h40);
        chk({7'h00, IRQ}, 8'h00);
    endtask
    task automatic t_fifo();
        {FIFO_COUNT, RX_LAST_PARTIAL, RX_LAST_BITS, RX_PARITY_MISSING, FIFO_OVERFLOW} = {IFS_FILL_MAX, 6'h2B};
        tick(1);
        {RX_LAST_PARTIAL, RX_PARITY_MISSING, FIFO_OVERFLOW} = 3'h0;
        ifs_host_model_inst.fifo_status(f1, f2);
        chk(f1, 8'h60);
        chk(f2, 8'h35);
        rchk(IFS_ADDR_FIFO2, 8'h20);
        {FIFO_UNDERFLOW, RX_LAST_PARTIAL, RX_LAST_BITS} = 5'h1B;
        // Read right behind the underflow edge so the checker sees it too
        rchk(IFS_ADDR_FIFO2, 8'h76);
        {FIFO_UNDERFLOW, RX_LAST_PARTIAL, FIFO_COUNT} = 9'h000;
        tick(2);
        rchk(IFS_ADDR_FIFO1, 8'h00);
        rchk(IFS_ADDR_FIFO2, 8'h60);
    endtask
    task automatic t_col();
        col(1'b1, 13'h0000, 3'h0, 1'b0);
        col(1'b0, 13'h0005, 3'h3, 1'b1);
        col(1'b0, 13'h0009, 3'h1, 1'b0);
        rchk(IFS_ADDR_COL, 8'h57);
        col(1'b1, 13'h0000, 3'h0, 1'b0);
        col(1'b0, 13'h0014, 3'h2, 1'b0);
        rchk(IFS_ADDR_COL, 8'h57);
        SET_DEFAULT = 1'b1;
        tick(1);
        SET_DEFAULT = 1'b0;
        rchk(IFS_ADDR_COL, 8'h00);
        rchk(IFS_ADDR_FIFO2, 8'h00);
    endtask
    task automatic t_ca();
        CA_START = 1'b1;
        tick(1);
        CA_START = 1'b0;
        for (n = 0; FIELD_ON !== 1'b1 && n < 200; n++) tick(1);
        chk({7'h00, n >= 115 && n <= 135}, 8'h01);
        for (n = 0; IRQ !== 1'b1 && n < 700; n++) tick(1);
        chk({7'h00, n >= 615 && n <= 635}, 8'h01);
        rchk(IFS_ADDR_TF, 8'h02);
        RF_OFF = 1'b1;
        tick(1);
        RF_OFF = 1'b0;
        EXT_FIELD_PIN = 1'b1;
        tick(10);
        CA_START = 1'b1;
        tick(1);
        CA_START = 1'b0;
        tick(200);
        chk({7'h00, FIELD_ON}, 8'h00);
        rchk(IFS_ADDR_TF, 8'h14);
        EXT_FIELD_PIN = 1'b0;
        tick(10);
        rchk(IFS_ADDR_TF, 8'h08);
    endtask
    initial begin
        tick(10);
        NRST = 1'b1;
        tick(1);
        t_reset();
        t_tf();
        t_ew();
        t_mask();
        t_fifo();
        t_col();
        t_ca();
        give_verdict();
    end
endmodule
